// ---- bsq_consts.vh ----
// Contract
// - Counted mode emits exactly the set number of whole carrier cycles per trigger.
// - Gated mode passes carrier only while the gate is active.
// - Gate polarity bit picks active high or active low gate level.
// - Internal source: period timer expiry starts each repeating burst.
// - External source: one burst per qualifying edge supplied by outside party.
// - External source: edge bit selects rising or falling trigger edge.
// - External gate: sampled level of external input decides carrier output.
// - Manual source: one burst per manual trigger command.
// - Every burst starts the carrier at the programmed start phase; gated mode does not reload the phase, it runs free.
// - Burst period applies only to internal source, sets timer period.
// - Cycle count applies only in counted mode, sets cycles per burst.
// - Infinite count outputs carrier continuously after first accepted trigger.
// - Internal or manual: burst start delayed by trigger delay, never below minimum.
// - Internal or manual: trigger output rising, falling aligned, or off.
`ifndef BSQ_CONSTS_VH
`define BSQ_CONSTS_VH

// ==========================================================================
// Register offsets
// ==========================================================================
`define BSQ_REG_CTRL      4'h0
`define BSQ_REG_CYCLES    4'h1
`define BSQ_REG_PERIOD    4'h2
`define BSQ_REG_DELAY     4'h3
`define BSQ_REG_PHASE     4'h4
`define BSQ_REG_FREQ      4'h5
`define BSQ_REG_STATUS    4'h6
`define BSQ_REG_MANUAL    4'h7
`define BSQ_REG_COUNT     8

// ==========================================================================
// Control field positions
// ==========================================================================
`define BSQ_CTRL_GATED    0
`define BSQ_CTRL_SRC_LO   1
`define BSQ_CTRL_SRC_HI   2
`define BSQ_CTRL_POL_NEG  3
`define BSQ_CTRL_FALLING  4
`define BSQ_CTRL_TOUT_LO  5
`define BSQ_CTRL_TOUT_HI  6
`define BSQ_CTRL_INFINITE 7
`define BSQ_CTRL_ENABLE   8
`define BSQ_CTRL_WIDTH    9

// Source and trigger-output encodings
`define BSQ_SRC_INTERNAL  2'h0
`define BSQ_SRC_EXTERNAL  2'h1
`define BSQ_SRC_MANUAL    2'h2
`define BSQ_TOUT_OFF      2'h0
`define BSQ_TOUT_RISE     2'h1
`define BSQ_TOUT_FALL     2'h2

// ==========================================================================
// Reset values
// ==========================================================================
`define BSQ_RST_CTRL      9'h000
`define BSQ_RST_CYCLES    32'h0000_0001
`define BSQ_RST_PERIOD    32'h000f_4240
`define BSQ_RST_DELAY     32'h0000_0000
`define BSQ_RST_PHASE     32'h0000_0000
`define BSQ_RST_FREQ      32'h0001_0000

// ==========================================================================
// Timing
// ==========================================================================
`define BSQ_CLK_NS        10
`define BSQ_MIN_DELAY_NS  20
`define BSQ_MIN_DELAY_CYC ((`BSQ_MIN_DELAY_NS + `BSQ_CLK_NS - 1) / `BSQ_CLK_NS)
`define BSQ_TOUT_NS       100
`define BSQ_TOUT_CYC      (`BSQ_TOUT_NS / `BSQ_CLK_NS)

`endif

// ---- bsq_regfile.v ----
`timescale 1ns/1ps
`include "bsq_consts.vh"

// Small register memory with registered read data
module bsq_regfile (
    // Clock and reset
    input  wire        aclk,
    input  wire        aresetn,
    // Write port
    input  wire        wr_en,
    input  wire [2:0]  wr_idx,
    input  wire [31:0] wr_data,
    input  wire [3:0]  wr_strb,
    // Read port
    input  wire [2:0]  rd_idx,
    output reg  [31:0] rd_data,
    // Flat view of all words
    output wire [255:0] words
);

    reg [31:0] mem [0:7];
    genvar g;

    // ======================================================================
    // Storage with byte strobes
    // ======================================================================
    generate
        for (g = 0; g < 8; g = g + 1) begin : g_word
            assign words[g*32 +: 32] = mem[g];
            always @(posedge aclk) begin
                if (!aresetn) begin
                    case (g)
                        1:       mem[g] <= `BSQ_RST_CYCLES;
                        2:       mem[g] <= `BSQ_RST_PERIOD;
                        5:       mem[g] <= `BSQ_RST_FREQ;
                        default: mem[g] <= 32'h0000_0000;
                    endcase
                end else if (wr_en && wr_idx == g) begin
                    if (wr_strb[0]) mem[g][7:0]   <= wr_data[7:0];
                    if (wr_strb[1]) mem[g][15:8]  <= wr_data[15:8];
                    if (wr_strb[2]) mem[g][23:16] <= wr_data[23:16];
                    if (wr_strb[3]) mem[g][31:24] <= wr_data[31:24];
                end
            end
        end
    endgenerate

    // Registered read
    always @(posedge aclk) begin
        if (!aresetn)
            rd_data <= 32'h0000_0000;
        else
            rd_data <= mem[rd_idx];
    end

endmodule // bsq_regfile

// ---- bsq_burst_sequencer.v ----
// The address map and the AXI4-Lite register port are this design's own decisions.
`timescale 1ns/1ps
`include "bsq_consts.vh"

// Burst sequencer with AXI4-Lite register access
module bsq_burst_sequencer (
    // Clock and reset
    input  wire        aclk,
    input  wire        aresetn,
    // AXI4-Lite write address
    input  wire        s_axi_awvalid,
    output reg         s_axi_awready,
    input  wire [5:0]  s_axi_awaddr,
    // AXI4-Lite write data
    input  wire        s_axi_wvalid,
    output reg         s_axi_wready,
    input  wire [31:0] s_axi_wdata,
    input  wire [3:0]  s_axi_wstrb,
    // AXI4-Lite write response
    output reg         s_axi_bvalid,
    input  wire        s_axi_bready,
    output reg  [1:0]  s_axi_bresp,
    // AXI4-Lite read address
    input  wire        s_axi_arvalid,
    output reg         s_axi_arready,
    input  wire [5:0]  s_axi_araddr,
    // AXI4-Lite read data
    output reg         s_axi_rvalid,
    input  wire        s_axi_rready,
    output reg  [31:0] s_axi_rdata,
    output reg  [1:0]  s_axi_rresp,
    // External trigger or gate pin
    input  wire        ext_trig_in,
    // Burst outputs
    output reg         carrier_en,
    output reg  [31:0] carrier_phase,
    output reg         trig_out
);

    // ======================================================================
    // State codes
    // ======================================================================
    localparam [1:0] ST_IDLE  = 2'h0;
    localparam [1:0] ST_DELAY = 2'h1;
    localparam [1:0] ST_RUN   = 2'h2;
    localparam [1:0] ST_INF   = 2'h3;
    localparam [31:0] MIN_DLY = `BSQ_MIN_DELAY_CYC;
    localparam [7:0]  TOUT_LEN = `BSQ_TOUT_CYC;

    // Word index decode, shared by both address channels
    function [3:0] reg_index;
        input [5:0] addr;
        begin
            reg_index = {1'b0, addr[4:2]};
            if (addr[5] || addr[1:0] != 2'h0)
                reg_index = 4'hf;
        end
    endfunction

    // ======================================================================
    // Declarations
    // ======================================================================
    reg         aw_held;
    reg  [5:0]  aw_addr;
    reg         w_held;
    reg  [31:0] w_data;
    reg  [3:0]  w_strb;
    reg         rd_pend;
    reg         rd_err;
    reg         rd_stat;
    reg  [1:0]  state;
    reg  [31:0] delay_cnt;
    reg  [31:0] cycle_cnt;
    reg  [31:0] period_cnt;
    reg  [31:0] phase_acc;
    reg  [7:0]  tout_cnt;
    reg         manual_req;
    reg  [31:0] bursts_done;
    reg         ext_meta;
    reg         ext_sync;
    reg         ext_prev;
    wire [255:0] words;
    wire [31:0] rf_rdata;
    wire        do_write;
    wire [3:0]  w_idx;
    wire [3:0]  r_idx;
    wire        wr_regs;
    wire [31:0] ctrl;
    wire [31:0] cycles_set;
    wire [31:0] period_set;
    wire [31:0] delay_set;
    wire [31:0] phase_set;
    wire [31:0] freq_set;
    wire [1:0]  src;
    wire [1:0]  tout_mode;
    wire        gated;
    wire        enable;
    wire        infinite;
    wire        gate_active;
    wire        ext_edge;
    wire        timer_fire;
    wire        trig;
    wire [31:0] delay_eff;
    wire [32:0] phase_sum;
    wire        wrap;
    wire [31:0] status_word;

    // ======================================================================
    // AXI4-Lite write channel
    // ======================================================================
    assign do_write = aw_held && w_held && !s_axi_bvalid;
    assign w_idx    = reg_index(aw_addr);
    assign wr_regs  = do_write && (w_idx < 4'h6);

    // Address and data taken in either order, response after both
    always @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_awready <= 1'b1;
            s_axi_wready  <= 1'b1;
            s_axi_bvalid  <= 1'b0;
            s_axi_bresp   <= 2'h0;
            aw_held       <= 1'b0;
            w_held        <= 1'b0;
            aw_addr       <= 6'h00;
            w_data        <= 32'h0000_0000;
            w_strb        <= 4'h0;
        end else begin
            if (s_axi_awvalid && s_axi_awready) begin
                aw_held       <= 1'b1;
                aw_addr       <= s_axi_awaddr;
                s_axi_awready <= 1'b0;
            end
            if (s_axi_wvalid && s_axi_wready) begin
                w_held       <= 1'b1;
                w_data       <= s_axi_wdata;
                w_strb       <= s_axi_wstrb;
                s_axi_wready <= 1'b0;
            end
            if (do_write) begin
                s_axi_bvalid <= 1'b1;
                s_axi_bresp  <= (w_idx > 4'h7) ? 2'h2 : 2'h0;
                aw_held      <= 1'b0;
                w_held       <= 1'b0;
            end
            if (s_axi_bvalid && s_axi_bready) begin
                s_axi_bvalid  <= 1'b0;
                s_axi_awready <= 1'b1;
                s_axi_wready  <= 1'b1;
            end
        end
    end

    // ======================================================================
    // AXI4-Lite read channel
    // ======================================================================
    assign r_idx = reg_index(s_axi_araddr);
    assign status_word = {27'h0, ext_sync, gate_active, carrier_en, state};

    // Two-cycle read: memory read register, then data out
    always @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_arready <= 1'b1;
            s_axi_rvalid  <= 1'b0;
            s_axi_rdata   <= 32'h0000_0000;
            s_axi_rresp   <= 2'h0;
            rd_pend       <= 1'b0;
            rd_err        <= 1'b0;
            rd_stat       <= 1'b0;
        end else begin
            if (s_axi_arvalid && s_axi_arready) begin
                s_axi_arready <= 1'b0;
                rd_pend       <= 1'b1;
                rd_err        <= (r_idx > 4'h7);
                rd_stat       <= (r_idx == 4'h6) || (r_idx == 4'h7);
            end
            if (rd_pend) begin
                rd_pend      <= 1'b0;
                s_axi_rvalid <= 1'b1;
                s_axi_rresp  <= rd_err ? 2'h2 : 2'h0;
                if (rd_err)
                    s_axi_rdata <= 32'h0000_0000;
                else if (rd_stat)
                    s_axi_rdata <= status_word | {bursts_done[15:0], 16'h0};
                else
                    s_axi_rdata <= rf_rdata;
            end
            if (s_axi_rvalid && s_axi_rready) begin
                s_axi_rvalid  <= 1'b0;
                s_axi_arready <= 1'b1;
            end
        end
    end

    // Register storage
    bsq_regfile u_regs (
        .aclk    (aclk),
        .aresetn (aresetn),
        .wr_en   (wr_regs),
        .wr_idx  (w_idx[2:0]),
        .wr_data (w_data),
        .wr_strb (w_strb),
        .rd_idx  (r_idx[2:0]),
        .rd_data (rf_rdata),
        .words   (words)
    );

    // ======================================================================
    // Configuration fields
    // ======================================================================
    assign ctrl       = words[`BSQ_REG_CTRL*32 +: 32];
    assign cycles_set = words[`BSQ_REG_CYCLES*32 +: 32];
    assign period_set = words[`BSQ_REG_PERIOD*32 +: 32];
    assign delay_set  = words[`BSQ_REG_DELAY*32 +: 32];
    assign phase_set  = words[`BSQ_REG_PHASE*32 +: 32];
    assign freq_set   = words[`BSQ_REG_FREQ*32 +: 32];
    assign gated      = ctrl[`BSQ_CTRL_GATED];
    assign src        = ctrl[`BSQ_CTRL_SRC_HI:`BSQ_CTRL_SRC_LO];
    assign tout_mode  = ctrl[`BSQ_CTRL_TOUT_HI:`BSQ_CTRL_TOUT_LO];
    assign infinite   = ctrl[`BSQ_CTRL_INFINITE];
    assign enable     = ctrl[`BSQ_CTRL_ENABLE];

    // Manual command: one-cycle request, lost if the sequencer is busy
    always @(posedge aclk) begin
        if (!aresetn)
            manual_req <= 1'b0;
        else if (do_write && w_idx == `BSQ_REG_MANUAL && w_strb[0] && w_data[0])
            manual_req <= 1'b1;
        else
            manual_req <= 1'b0; // one burst per command, none queued
    end

    // ======================================================================
    // External input sync and edge detect
    // ======================================================================
    always @(posedge aclk) begin
        if (!aresetn) begin
            ext_meta <= 1'b0;
            ext_sync <= 1'b0;
            ext_prev <= 1'b0;
        end else begin
            ext_meta <= ext_trig_in;
            ext_sync <= ext_meta;
            ext_prev <= ext_sync;
        end
    end

    // Edge choice for external trigger
    assign ext_edge = ctrl[`BSQ_CTRL_FALLING] ? (ext_prev && !ext_sync)
                                              : (!ext_prev && ext_sync);
    // Gate level with polarity
    assign gate_active = ctrl[`BSQ_CTRL_POL_NEG] ? !ext_sync : ext_sync;

    // ======================================================================
    // Internal period timer
    // ======================================================================
    assign timer_fire = (period_cnt == 32'h0000_0000);

    // Counts down the burst period, only with internal source
    always @(posedge aclk) begin
        if (!aresetn)
            period_cnt <= `BSQ_RST_PERIOD;
        else if (!enable || gated || src != `BSQ_SRC_INTERNAL)
            period_cnt <= (period_set == 32'h0) ? 32'h0 : period_set - 32'h1;
        else if (timer_fire)
            period_cnt <= (period_set == 32'h0) ? 32'h0 : period_set - 32'h1;
        else
            period_cnt <= period_cnt - 32'h1;
    end

    // Selected trigger event
    assign trig = enable && !gated &&
                  ((src == `BSQ_SRC_INTERNAL && timer_fire) ||
                   (src == `BSQ_SRC_EXTERNAL && ext_edge) ||
                   (src == `BSQ_SRC_MANUAL && manual_req));

    // Delay clamped to hardware minimum, external starts at once
    assign delay_eff = (src == `BSQ_SRC_EXTERNAL) ? 32'h1 :
                       (delay_set < MIN_DLY) ? MIN_DLY : delay_set;

    // ======================================================================
    // Carrier phase accumulator
    // ======================================================================
    assign phase_sum = {1'b0, phase_acc} + {1'b0, freq_set};
    // Cycle ends when the step crosses the start phase, modulo the wrap
    assign wrap = phase_sum[32] ?
                  (phase_acc < phase_set || phase_sum[31:0] >= phase_set) :
                  (phase_acc < phase_set && phase_sum[31:0] >= phase_set);

    // Free-running, reloaded to start phase at each burst start
    always @(posedge aclk) begin
        if (!aresetn)
            phase_acc <= 32'h0000_0000;
        else if (state == ST_DELAY && delay_cnt == 32'h1)
            phase_acc <= phase_set;
        else
            phase_acc <= phase_sum[31:0];
    end

    // ======================================================================
    // Burst state machine
    // ======================================================================
    always @(posedge aclk) begin
        if (!aresetn) begin
            state       <= ST_IDLE;
            delay_cnt   <= 32'h0000_0000;
            cycle_cnt   <= 32'h0000_0000;
            bursts_done <= 32'h0000_0000;
        end else if (!enable || gated) begin
            state <= ST_IDLE;
        end else begin
            case (state)
                ST_IDLE: begin
                    if (trig) begin
                        state     <= ST_DELAY;
                        delay_cnt <= delay_eff;
                    end
                end
                ST_DELAY: begin
                    if (delay_cnt == 32'h1) begin
                        cycle_cnt <= cycles_set;
                        state     <= infinite ? ST_INF : ST_RUN;
                    end else begin
                        delay_cnt <= delay_cnt - 32'h1;
                    end
                end
                ST_RUN: begin
                    // Whole cycles counted by phase wrap past start
                    if (wrap) begin
                        if (cycle_cnt <= 32'h1) begin
                            state       <= ST_IDLE;
                            bursts_done <= bursts_done + 32'h1;
                        end else begin
                            cycle_cnt <= cycle_cnt - 32'h1;
                        end
                    end
                    // New triggers are not looked at here
                end
                ST_INF: state <= ST_INF; // runs until disabled or gated
                default: state <= ST_IDLE;
            endcase
        end
    end

    // ======================================================================
    // Outputs
    // ======================================================================
    always @(posedge aclk) begin
        if (!aresetn) begin
            carrier_en    <= 1'b0;
            carrier_phase <= 32'h0000_0000;
            trig_out      <= 1'b0;
            tout_cnt      <= 8'h00;
        end else begin
            carrier_phase <= phase_acc;
            if (gated)
                carrier_en <= enable && gate_active;
            else
                carrier_en <= enable
                              && (state == ST_RUN || state == ST_INF);
            // Pulse aligned to burst start, internal or manual only
            if (state == ST_DELAY && delay_cnt == 32'h1 && enable && !gated
                && src != `BSQ_SRC_EXTERNAL && tout_mode != `BSQ_TOUT_OFF)
                tout_cnt <= TOUT_LEN;
            else if (tout_cnt != 8'h00)
                tout_cnt <= tout_cnt - 8'h01;
            if (tout_mode == `BSQ_TOUT_RISE)
                trig_out <= (next_tout_active(tout_cnt, state, delay_cnt));
            else if (tout_mode == `BSQ_TOUT_FALL)
                trig_out <= !(next_tout_active(tout_cnt, state, delay_cnt));
            else
                trig_out <= 1'b0;
        end
    end

    // Pulse window: start edge at burst start, then counter
    function next_tout_active;
        input [7:0]  cnt;
        input [1:0]  st;
        input [31:0] dly;
        begin
            next_tout_active = (cnt > 8'h01) || (st == ST_DELAY && dly == 32'h1
                               && src != `BSQ_SRC_EXTERNAL);
        end
    endfunction

endmodule // bsq_burst_sequencer

// ---- bsq_seq_sva.sv ----
`timescale 1ns/1ps
// ==========
// Port checker for the burst sequencer
module bsq_seq_sva (
    // Clock and reset
    input wire        aclk,
    input wire        aresetn,
    // Register bus
    input wire        s_axi_awvalid,
    input wire        s_axi_awready,
    input wire [5:0]  s_axi_awaddr,
    input wire        s_axi_wvalid,
    input wire        s_axi_wready,
    input wire [31:0] s_axi_wdata,
    input wire        s_axi_bvalid,
    input wire        s_axi_bready,
    input wire        s_axi_arvalid,
    input wire        s_axi_arready,
    input wire        s_axi_rvalid,
    input wire        s_axi_rready,
    input wire [31:0] s_axi_rdata,
    // Trigger pin and burst outputs
    input wire        ext_trig_in,
    input wire        carrier_en,
    input wire        trig_out
);
    default clocking dc @(posedge aclk); endclocking
    default disable iff (!aresetn);
    reg [5:0]  sh_a;
    reg [31:0] sh_d;
    reg [8:0]  ctrl;
    // Shadow of the control word, taken when its write completes
    always @(posedge aclk) begin
        if (s_axi_awvalid && s_axi_awready) sh_a <= s_axi_awaddr;
        if (s_axi_wvalid && s_axi_wready) sh_d <= s_axi_wdata;
        if (!aresetn) ctrl <= 9'h000;
        else if (s_axi_bvalid && s_axi_bready && sh_a == 6'h00)
            ctrl <= sh_d[8:0];
    end
    a_write_hold: assert property (s_axi_bvalid && !s_axi_bready |=>
        s_axi_bvalid) else $error("write answer dropped");
    a_ready_low: assert property (s_axi_bvalid |->
        !s_axi_awready && !s_axi_wready) else $error("ready while busy");
    a_write_answer: assert property (s_axi_awvalid && s_axi_awready &&
        s_axi_wvalid && s_axi_wready |-> ##[1:2] s_axi_bvalid)
        else $error("no write answer");
    a_read_hold: assert property (s_axi_rvalid && !s_axi_rready |=>
        s_axi_rvalid && $stable(s_axi_rdata)) else $error("read data moved");
    a_read_answer: assert property (s_axi_arvalid && s_axi_arready |->
        ##[1:3] s_axi_rvalid) else $error("no read answer");
    a_pulse_width: assert property ($rose(trig_out) |=>
        trig_out [*8]) else $error("trigger pulse short");
    a_gate_level: assert property ((ctrl[0] && ctrl[8] &&
        $stable(ctrl) && $stable(ext_trig_in)) [*6] |->
        carrier_en == (ext_trig_in ^ ctrl[3])) else $error("gate wrong");
    a_endless_burst: assert property (ctrl[7] && !ctrl[0] &&
        ctrl[8] && carrier_en && !(s_axi_wvalid && s_axi_wready) &&
        !s_axi_bvalid |=> carrier_en) else $error("endless burst stopped");
    // Main scenarios
    cover property ($rose(carrier_en));
    cover property ($fell(trig_out));
    cover property (ctrl[0] && carrier_en);
endmodule // bsq_seq_sva

bind bsq_burst_sequencer bsq_seq_sva chk_i (.*);

// ---- bsq_trig_peer.sv ----
`timescale 1ns/1ps
// ==========
// Far side: trigger pin source and trigger output watcher
module bsq_trig_peer (
    // Clock and watched output
    input  wire aclk,
    input  wire trig_out,
    // Trigger or gate pin
    output reg  ext_pin
);
    integer n_rise = 0;
    integer n_fall = 0;
    reg     last = 1'b0;
    initial ext_pin = 1'b0;
    // Move the pin just after a clock edge
    task set_pin(input v); begin
        @(posedge aclk);
        ext_pin <= v;
    end endtask
    // Count edges of the trigger output
    always @(posedge aclk) begin
        if (trig_out === 1'b1 && !last) n_rise <= n_rise + 1;
        if (trig_out === 1'b0 && last) n_fall <= n_fall + 1;
        last <= trig_out;
    end
endmodule // bsq_trig_peer

// ---- tb_top.sv ----
`timescale 1ns/1ps
`include "bsq_consts.vh"
// ==========
// Burst sequencer bench
module tb_top;
    reg         aclk = 1'b0, aresetn = 1'b0, pv = 1'b0;
    reg         awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0;
    reg         arvalid = 1'b0, rready = 1'b0;
    reg  [5:0]  awaddr = 6'h00, araddr = 6'h00;
    reg  [31:0] wdata = 32'h0, ph0;
    wire        awready, wready, bvalid, arready, rvalid, ext_pin;
    wire        carrier_en, trig_out;
    wire [1:0]  bresp, rresp;
    wire [31:0] rdata, phase;
    integer     failures = 0, n_checks = 0;
    integer     hi, rises, first, i, e, r0, r1, f2;
    // Design and far side
    bsq_burst_sequencer bsq_burst_sequencer_i (
        .aclk(aclk), .aresetn(aresetn), .s_axi_awvalid(awvalid),
        .s_axi_awready(awready), .s_axi_awaddr(awaddr),
        .s_axi_wvalid(wvalid), .s_axi_wready(wready),
        .s_axi_wdata(wdata), .s_axi_wstrb(4'hf), .s_axi_bvalid(bvalid),
        .s_axi_bready(bready), .s_axi_bresp(bresp),
        .s_axi_arvalid(arvalid), .s_axi_arready(arready),
        .s_axi_araddr(araddr), .s_axi_rvalid(rvalid),
        .s_axi_rready(rready), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
        .ext_trig_in(ext_pin), .carrier_en(carrier_en),
        .carrier_phase(phase), .trig_out(trig_out));
    bsq_trig_peer bsq_trig_peer_i (
        .aclk(aclk), .trig_out(trig_out), .ext_pin(ext_pin));
    // Clock
    initial begin
        forever #5 aclk = ~aclk;
    end
    // Compare and count
    task chk(input [31:0] got, input [31:0] exp); begin
        n_checks = n_checks + 1;
        if (got !== exp) begin
            failures = failures + 1;
            $display("BAD %0t got %h want %h", $time, got, exp);
        end
    end endtask
    // Register write; places past the map answer with an error
    task wr(input [5:0] a, input [31:0] d); begin
        @(posedge aclk);
        awaddr <= a;
        wdata <= d;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        bready <= 1'b1;
        do begin
            @(posedge aclk);
            if (awready) awvalid <= 1'b0;
            if (wready) wvalid <= 1'b0;
        end while (!bvalid);
        bready <= 1'b0;
        chk(bresp, a > 6'h1c ? 32'h2 : 32'h0);
    end endtask
    // Register read against an expected word
    task rd(input [5:0] a, input [31:0] x); begin
        @(posedge aclk);
        araddr <= a;
        arvalid <= 1'b1;
        rready <= 1'b1;
        do begin
            @(posedge aclk);
            if (arready) arvalid <= 1'b0;
        end while (!rvalid);
        rready <= 1'b0;
        chk(rdata, x);
        chk(rresp, a > 6'h1c ? 32'h2 : 32'h0);
    end endtask
    // Watch the carrier: busy cycles, burst starts, first start
    task meas(input integer n); begin
        hi = 0;
        rises = 0;
        first = -1;
        for (i = 0; i < n; i = i + 1) begin
            @(posedge aclk);
            #1;
            if (carrier_en === 1'b1 && !pv) rises = rises + 1;
            if (carrier_en === 1'b1 && first < 0) ph0 = phase;
            if (carrier_en === 1'b1 && first < 0) first = i;
            if (carrier_en === 1'b1) hi = hi + 1;
            pv = carrier_en;
        end
    end endtask
    // Manual burst: set delay and mode, fire once or twice, watch
    task man(input [31:0] ctl, input [31:0] dly, input tw); begin
        wr(6'h0c, dly);
        wr(6'h00, ctl);
        r0 = bsq_trig_peer_i.n_rise;
        r1 = bsq_trig_peer_i.n_fall;
        fork
            begin
                wr(6'h1c, 32'h1);
                if (tw) wr(6'h1c, 32'h1);
            end
            meas(80);
        join
    end endtask
    // Verdict
    task results; begin
        $display("checks %0d failures %0d", n_checks, failures);
        if (failures == 0 && n_checks > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    end endtask
    // Main sequence; a carrier cycle is four clocks
    initial begin
        repeat (3) @(posedge aclk);
        aresetn <= 1'b1;
        rd(6'h04, 32'h1);
        rd(6'h08, `BSQ_RST_PERIOD);
        rd(6'h14, `BSQ_RST_FREQ);
        rd(6'h20, 32'h0);
        wr(6'h24, 32'h1);
        wr(6'h14, 32'h4000_0000);
        wr(6'h10, 32'h8000_0000);
        wr(6'h04, 32'h3);
        man(32'h124, 32'h2, 1'b1);
        chk(hi, 12);
        chk(rises, 1);
        chk(ph0, 32'h8000_0000);
        chk(bsq_trig_peer_i.n_rise - r0, 1);
        f2 = first;
        man(32'h124, 32'h0, 1'b0);
        chk(first, f2);
        man(32'h144, 32'd20, 1'b0);
        chk(first - f2, 18);
        chk(bsq_trig_peer_i.n_fall - r1, 1);
        wr(6'h08, 32'd60);
        r0 = bsq_trig_peer_i.n_rise;
        fork
            begin
                wr(6'h00, 32'h100);
                repeat (540) @(posedge aclk);
                wr(6'h00, 32'h104);
            end
            meas(700);
        join
        chk(hi, rises * 12);
        chk(rises >= 8 && rises <= 11, 1);
        chk(bsq_trig_peer_i.n_rise - r0, 0);
        for (e = 0; e < 2; e = e + 1) begin
            wr(6'h00, e ? 32'h112 : 32'h102);
            bsq_trig_peer_i.set_pin(1'b1);
            meas(40);
            chk(rises, 1 - e);
            bsq_trig_peer_i.set_pin(1'b0);
            meas(40);
            chk(rises, e);
        end
        for (e = 0; e < 4; e = e + 1) begin
            wr(6'h00, e[1] ? 32'h10b : 32'h103);
            bsq_trig_peer_i.set_pin(e[0]);
            meas(20);
            chk(carrier_en, e[0] ^ e[1]);
            chk(hi > 10, e[0] ^ e[1]);
        end
        wr(6'h00, 32'h0);
        man(32'h184, 32'h2, 1'b0);
        meas(200);
        chk(hi, 200);
        results;
    end
    // Watchdog against a hung handshake
    initial begin
        #100000;
        failures = failures + 1;
        results;
    end
endmodule // tb_top
